/* cic_irq_control_unit.v */
// Top of the interrupt control unit: master and slave cores, acknowledge cycle, vector and cascade outputs.
`timescale 1ns/1ps
`include "cic_defines.vh"

module cic_irq_control_unit (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Request sources
   input wire [7:0] external_request_inputs_i,
   input wire [7:0] internal_request_i,
   // Programming of the two cores
   input wire master_edge_mode_i,
   input wire slave_edge_mode_i,
   input wire [2:0] master_prio_base_i,
   input wire [2:0] slave_prio_base_i,
   input wire [4:0] master_vector_base_i,
   input wire [4:0] slave_vector_base_i,
   input wire [3:0] cascade_enable_i,
   // Processor side
   input wire irq_acknowledge_n_i,
   output wire irq_o,
   output wire [7:0] data_o,
   output wire data_oe_n_o,
   // Outside slave selection
   output wire cascade_active_o,
   output wire [1:0] cascade_select_o
);

   // ==========================================================================
   // Declarations
   wire [7:0] m_req;
   wire [7:0] m_pend;
   wire [7:0] s_pend;
   wire m_any;
   wire s_any;
   wire [2:0] m_win;
   wire [2:0] s_win;
   wire [7:0] m_force;
   wire ack_fall;
   wire win_is_slave;
   wire win_is_cascade;
   reg ack_prev_reg;
   reg irq_reg;
   reg [7:0] data_reg;
   reg [7:0] data_next;
   reg data_oe_n_reg;
   reg casc_act_reg;
   reg casc_act_next;
   reg [1:0] casc_sel_reg;
   reg [1:0] casc_sel_next;
   reg m_clear;
   reg s_clear;

   // Vector is the programmed base with the slot number below it
   function [7:0] cic_vector;
      input [4:0] base;
      input [2:0] idx;
      begin
         cic_vector = {base, idx};
      end
   endfunction

   // ==========================================================================
   // Master input map
   // The internal slave sits on the last master slot so all four cascade pins stay free
   assign m_req = {s_any, external_request_inputs_i[6:0]}; // see RL1
   // Slave slot follows the slave's level; an edge latch there would strand requests
   assign m_force = 8'h80;

   // ==========================================================================
   // Cores
   cic_pic_core u_master (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .req_i(m_req), // see RL2
      .edge_mode_i(master_edge_mode_i),
      .force_level_i(m_force),
      .prio_base_i(master_prio_base_i), // see RL6
      .ack_clear_i(m_clear),
      .ack_idx_i(m_win),
      .pending_o(m_pend),
      .any_o(m_any),
      .win_o(m_win)
   );

   cic_pic_core u_slave (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .req_i(internal_request_i), // see RL2
      .edge_mode_i(slave_edge_mode_i),
      .force_level_i(8'h00),
      .prio_base_i(slave_prio_base_i),
      .ack_clear_i(s_clear),
      .ack_idx_i(s_win),
      .pending_o(s_pend),
      .any_o(s_any),
      .win_o(s_win)
   );

   // ==========================================================================
   // Acknowledge detection
   // The strobe is decoded outside from the bus status; only its falling edge counts
   assign ack_fall = ack_prev_reg & ~irq_acknowledge_n_i; // see RL9
   assign win_is_slave = m_any && (m_win == `CIC_SLAVE_SLOT);
   assign win_is_cascade = m_any && !win_is_slave && (m_win[2] == 1'h0) && cascade_enable_i[m_win[1:0]];

   // ==========================================================================
   // Acknowledge decision
   // Cascaded winners leave the data bus to the outside slave
   always @* begin
      m_clear = 1'h0;
      s_clear = 1'h0;
      data_next = data_reg;
      casc_act_next = 1'h0;
      casc_sel_next = casc_sel_reg;
      if (ack_fall) begin
         if (!m_any) begin
            data_next = cic_vector(master_vector_base_i, `CIC_SPURIOUS_IDX); // Nothing pending
         end else if (win_is_slave) begin
            s_clear = 1'h1; // see RL10
            data_next = cic_vector(slave_vector_base_i, s_win); // see RL10
         end else if (win_is_cascade) begin
            m_clear = 1'h1;
            casc_act_next = 1'h1; // see RL8
            casc_sel_next = m_win[1:0]; // see RL8
         end else begin
            m_clear = 1'h1; // see RL10
            data_next = cic_vector(master_vector_base_i, m_win); // see RL10
         end
      end
   end

   // ==========================================================================
   // Output flops
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_prev_reg <= 1'h1;
         irq_reg <= 1'h0;
         data_reg <= `CIC_VECTOR_RST;
         data_oe_n_reg <= 1'h1;
         casc_act_reg <= 1'h0;
         casc_sel_reg <= 2'h0;
      end else begin
         ack_prev_reg <= irq_acknowledge_n_i;
         irq_reg <= m_any; // see RL5
         data_reg <= data_next;
         data_oe_n_reg <= ~(ack_fall & ~win_is_cascade); // Drive for one cycle only
         casc_act_reg <= casc_act_next;
         casc_sel_reg <= casc_sel_next;
      end
   end

   assign irq_o = irq_reg;
   assign data_o = data_reg;
   assign data_oe_n_o = data_oe_n_reg;
   assign cascade_active_o = casc_act_reg;
   assign cascade_select_o = casc_sel_reg;

endmodule // cic_irq_control_unit

/* cic_defines.vh */
// Constants for the cascaded interrupt controller: slot map and reset values.
//
// Contract
// RL1: The unit is two controller cores, a master and a slave, and the slave's request drives one master input.
// RL2: The unit takes eight external request inputs and eight internal peripheral request signals; the code ignores external input 7.
// RL3: Every request input owns a pending bit that is set whenever that request is asserted.
// RL4: Each core is set to recognise its requests either as a high level or as a rising edge.
// RL5: A priority resolver picks the highest-priority pending request under the programmed order and drives one request to the core.
// RL6: Out of reset the order puts master input 0 first and master input 7 last.
// RL7: Software can move the priority order away from that default by programming the cores.
// RL8: Up to four outside slave controllers can hang off the master through the four low-numbered external request pins.
// RL9: With outside slaves fitted, outside logic builds the acknowledge strobe from address strobe, data/code, write/read and memory/IO.
// RL10: An acknowledge clears the winning edge-mode pending bit and puts the winner's vector on the data bus.
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

// ==========================================================================
// Slot map
`define CIC_SLAVE_SLOT 3'h7
`define CIC_SPURIOUS_IDX 3'h7
`define CIC_NUM_CASCADE 4

// ==========================================================================
// Reset values
`define CIC_PRIO_BASE_RST 3'h0
`define CIC_VECTOR_RST 8'h00
`define CIC_PEND_RST 8'h00

`endif

/* cic_pic_core.v */
// One eight-input controller core: pending bits, trigger mode and rotating priority resolver.
`timescale 1ns/1ps
`include "cic_defines.vh"

module cic_pic_core (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Requests and programming
   input wire [7:0] req_i,
   input wire edge_mode_i,
   input wire [7:0] force_level_i,
   input wire [2:0] prio_base_i,
   // Acknowledge clear
   input wire ack_clear_i,
   input wire [2:0] ack_idx_i,
   // Resolver results
   output wire [7:0] pending_o,
   output wire any_o,
   output wire [2:0] win_o
);

   reg [7:0] pend_reg;
   reg [7:0] pend_next;
   reg [7:0] req_prev_reg;
   wire [7:0] rise;
   integer k;

   // ==========================================================================
   // Resolver
   // Walk from the base slot upward with wrap; first pending slot wins
   function [2:0] cic_resolve;
      input [7:0] pend;
      input [2:0] base;
      integer j;
      reg found;
      reg [2:0] slot;
      begin
         cic_resolve = base;
         found = 1'h0;
         slot = base;
         for (j = 0; j < 8; j = j + 1) begin
            slot = base + j[2:0];
            if (!found && pend[slot]) begin
               cic_resolve = slot;
               found = 1'h1;
            end
         end
      end
   endfunction

   assign rise = req_i & ~req_prev_reg;

   // ==========================================================================
   // Pending bits
   // A new edge in the clearing cycle survives, so no event is dropped
   always @* begin
      pend_next = pend_reg;
      for (k = 0; k < 8; k = k + 1) begin
         if (!edge_mode_i || force_level_i[k]) begin
            pend_next[k] = req_i[k]; // see RL4
         end else begin
            if (ack_clear_i && ack_idx_i == k[2:0]) begin
               pend_next[k] = 1'h0; // see RL10
            end
            if (rise[k]) begin
               pend_next[k] = 1'h1; // see RL3
            end
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_reg <= `CIC_PEND_RST;
         req_prev_reg <= 8'h00;
      end else begin
         pend_reg <= pend_next;
         req_prev_reg <= req_i;
      end
   end

   assign pending_o = pend_reg;
   assign any_o = |pend_reg; // see RL5
   assign win_o = cic_resolve(pend_reg, prio_base_i); // see RL7

endmodule // cic_pic_core

/* cic_props.sv */
// Port checker for the interrupt control unit.
`timescale 1ns/1ps
module cic_props (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Inputs
   input wire [7:0] external_request_inputs_i,
   input wire [7:0] internal_request_i,
   input wire master_edge_mode_i,
   input wire slave_edge_mode_i,
   input wire [3:0] cascade_enable_i,
   input wire irq_acknowledge_n_i,
   // Outputs
   input wire irq_o,
   input wire [7:0] data_o,
   input wire data_oe_n_o,
   input wire cascade_active_o,
   input wire [1:0] cascade_select_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // =====================
   // Steps of a request and of an acknowledge
   sequence req_s; !master_edge_mode_i && |external_request_inputs_i[6:0]; endsequence
   sequence idle_s;
      !master_edge_mode_i && !slave_edge_mode_i && !external_request_inputs_i[6:0] && !internal_request_i;
   endsequence
   sequence ack_s; irq_acknowledge_n_i ##1 !irq_acknowledge_n_i; endsequence
   // Slave path is one stage longer, hence three quiet samples
   req_irq_a: assert property (req_s |-> ##2 irq_o) else $error("irq late");
   idle_irq_a: assert property (idle_s [*3] |-> ##2 !irq_o) else $error("irq stuck");
   ack_answer_a: assert property (ack_s |=> !data_oe_n_o || cascade_active_o) else $error("no answer");
   oe_cause_a: assert property (!data_oe_n_o |->
      $past(irq_acknowledge_n_i, 2) && !$past(irq_acknowledge_n_i))
      else $error("stray vector");
   oe_pulse_a: assert property (!data_oe_n_o |=> data_oe_n_o) else $error("long vector");
   casc_pulse_a: assert property (cascade_active_o |=> !cascade_active_o) else $error("long cascade");
   // Enable is judged as it stood at the acknowledge edge, so a later change cannot fire it
   casc_sel_a: assert property (cascade_active_o |-> data_oe_n_o &&
      ((($past(cascade_enable_i) >> cascade_select_o) & 4'h1) == 4'h1))
      else $error("bad cascade");
   data_hold_a: assert property ($changed(data_o) |-> !data_oe_n_o) else $error("vector moved");
endmodule // cic_props
bind cic_irq_control_unit cic_props i_props (.clk_i, .rst_n_i, .external_request_inputs_i, .internal_request_i,
   .master_edge_mode_i, .slave_edge_mode_i, .cascade_enable_i, .irq_acknowledge_n_i, .irq_o, .data_o,
   .data_oe_n_o, .cascade_active_o, .cascade_select_o);

/* cic_cpu_model.sv */
// Processor-side model: raises one acknowledge and takes the answer.
`timescale 1ns/1ps
module cic_cpu_model (
   // Clock
   input wire clk_i,
   // Answer from the unit
   input wire [7:0] data_i,
   input wire data_oe_n_i,
   input wire cascade_active_i,
   // Strobe to the unit
   output reg irq_acknowledge_n_o
);
   reg [7:0] vec_reg;
   reg took_reg;
   reg casc_reg;
   initial irq_acknowledge_n_o = 1'h1;
   // Strobe spans one sampling edge, then a gap so it counts once
   task acknowledge;
      @(negedge clk_i) irq_acknowledge_n_o = 1'h0;
      @(negedge clk_i) vec_reg = data_i;
      took_reg = !data_oe_n_i;
      casc_reg = cascade_active_i;
      irq_acknowledge_n_o = 1'h1;
      repeat (2) @(negedge clk_i);
   endtask
endmodule // cic_cpu_model

/* cic_irq_control_unit_tb.sv */
// Self-checking bench for the interrupt control unit.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch %0t got %h want %h", $time, (a), (b)); end end
module cic_irq_control_unit_tb;
   reg clk_i = 1'h0;
   reg rst_n_i = 1'h0;
   reg [7:0] ext = 8'h00;
   reg [7:0] intr = 8'h00;
   reg m_edge = 1'h0;
   reg [2:0] m_base = 3'h0;
   reg s_edge = 1'h0;
   reg [2:0] s_base = 3'h0;
   reg [3:0] casc_en = 4'h0;
   wire ack_n, irq, oe_n, casc;
   wire [7:0] data;
   wire [1:0] sel;
   integer err_count = 0;
   integer check_count = 0;
   integer cycles = 0;
   localparam [4:0] m_vec = 5'h0A;
   localparam [4:0] s_vec = 5'h15;
   // =====================
   // Unit, processor model and clock
   cic_irq_control_unit i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .external_request_inputs_i(ext),
      .internal_request_i(intr), .master_edge_mode_i(m_edge), .slave_edge_mode_i(s_edge),
      .master_prio_base_i(m_base), .slave_prio_base_i(s_base), .master_vector_base_i(m_vec),
      .slave_vector_base_i(s_vec), .cascade_enable_i(casc_en), .irq_acknowledge_n_i(ack_n), .irq_o(irq),
      .data_o(data), .data_oe_n_o(oe_n), .cascade_active_o(casc), .cascade_select_o(sel));
   cic_cpu_model i_cpu (.clk_i(clk_i), .data_i(data), .data_oe_n_i(oe_n), .cascade_active_i(casc),
      .irq_acknowledge_n_o(ack_n));
   always #25 clk_i = ~clk_i;
   // Hang guard; the run needs about eighty cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 500) begin
         err_count++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task step(input integer n);
      repeat (n) @(negedge clk_i);
   endtask
   // A cascade answer carries only the select, never a vector
   task ack_chk(input [7:0] v, input c);
      i_cpu.acknowledge;
      `CHK(i_cpu.casc_reg, c)
      `CHK(i_cpu.took_reg, !c)
      `CHK(c ? {6'h00, sel} : i_cpu.vec_reg, v)
   endtask
   task t_reset;
      `CHK({irq, oe_n, casc, sel, data}, 13'h0800)
   endtask
   // Two level requests, default order then rotated; pin 7 is ignored
   task t_prio;
      ext = 8'h0A;
      step(2);
      `CHK(irq, 1'h1)
      ack_chk({m_vec, 3'h1}, 1'h0);
      m_base = 3'h2;
      ack_chk({m_vec, 3'h3}, 1'h0);
      `CHK(irq, 1'h1)
      ext = 8'h80;
      m_base = 3'h0;
      step(3);
      `CHK(irq, 1'h0)
      ack_chk({m_vec, 3'h7}, 1'h0);
   endtask
   // A one-cycle rise is held until acknowledged
   task t_edge;
      m_edge = 1'h1;
      ext = 8'h20;
      step(1);
      ext = 8'h00;
      step(2);
      `CHK(irq, 1'h1)
      // A new rise in the acknowledge cycle must survive the clear
      fork
         ack_chk({m_vec, 3'h5}, 1'h0);
         begin
            @(negedge clk_i) ext = 8'h20;
            @(negedge clk_i) ext = 8'h00;
         end
      join
      `CHK(irq, 1'h1)
      ack_chk({m_vec, 3'h5}, 1'h0);
      `CHK(irq, 1'h0)
      m_edge = 1'h0;
   endtask
   task t_slave;
      intr = 8'h10;
      step(3);
      `CHK(irq, 1'h1)
      ack_chk({s_vec, 3'h4}, 1'h0);
      intr = 8'h00;
   endtask
   task t_casc;
      casc_en = 4'h4;
      ext = 8'h04;
      step(2);
      ack_chk(8'h02, 1'h1);
      casc_en = 4'hF;
      ext = 8'h09;
      step(2);
      ack_chk(8'h00, 1'h1);
      ext = 8'h00;
   endtask
   // Slave in edge mode with a rotated order: two one-cycle rises served from the base upward
   task t_slave_edge;
      step(2);
      s_edge = 1'h1;
      s_base = 3'h5;
      intr = 8'h41;
      step(1);
      intr = 8'h00;
      step(3);
      `CHK(irq, 1'h1)
      ack_chk({s_vec, 3'h6}, 1'h0);
      ack_chk({s_vec, 3'h0}, 1'h0);
      `CHK(irq, 1'h0)
      s_edge = 1'h0;
      s_base = 3'h0;
   endtask
   // Reset in mid-run clears all; a held request counts again from the first edge after release
   task t_rerun;
      step(1);
      ext = 8'h02;
      step(2);
      `CHK(irq, 1'h1)
      rst_n_i = 1'h0;
      step(2);
      `CHK({irq, oe_n, casc, sel, data}, 13'h0800)
      rst_n_i = 1'h1;
      step(1);
      `CHK(irq, 1'h0)
      step(1);
      `CHK(irq, 1'h1)
      ext = 8'h00;
   endtask
   initial begin
      step(10);
      rst_n_i = 1'h1;
      step(1);
      t_reset;
      t_prio;
      t_edge;
      t_slave;
      t_slave_edge;
      t_casc;
      t_rerun;
      give_verdict;
   end
endmodule // cic_irq_control_unit_tb
